// file: flash_array_model.sv
// Behavioural program memory and EEPROM array facing the block
`timescale 1ns/100ps
module flash_array_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic mem_rd,
  input wire logic [21:0] mem_rd_addr,
  input wire logic ee_rd,
  input wire logic [7:0] ee_addr,
  output logic [7:0] mem_rd_data,
  output logic [7:0] ee_rdata
);
  // Byte per read; between reads the data lines toggle, so stale use shows
  always_ff @(posedge clock or posedge rst) begin
    if (rst) mem_rd_data <= 8'h00;
    else if (mem_rd) mem_rd_data <= mem_rd_addr[7:0] ^ 8'h5a;
    else mem_rd_data <= ~mem_rd_data;
  end
  assign ee_rdata = ee_rd ? ee_addr ^ 8'hc3 : ~(ee_addr ^ 8'hc3);
endmodule

// file: flash_self_access.sv
// Flash self-programming controller with Wishbone register slave
// How it works
// - Byte reads, 8-byte programs, 64-byte erases
// - No bulk erase from software
// - Stall fetch; timer ends write or erase
// - Any byte accepted; invalid code runs as no-op
// - Program memory bytes move only through the table latch
// - Table blocks need no word alignment
// - Table write picks holding register by pointer[2:0]
// - Unlock port stores nothing, reads zero
// - Program select one: flash, zero: EEPROM
// - Config select overrides program select
// - Erase enable makes next start erase row
// - Write permit clear at reset, blocks writes
// - Abort flag on reset mid-write, cleared on completion
// - Abort keeps space select bits
// - Write start set-only, hardware clears
// - Done flag set on completion, software clears
// - Read start one-cycle, blocked when program select
// - Control register layout, bit 5 zero
// - Table latch is an 8-bit register
// - 55h then AAh before write start
// - Erase row from pointer[21:6]
// - Processor stalled for whole erase
// - Pointer keep, post-inc, post-dec, pre-inc on 21 bits
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/100ps
module flash_self_access #(
  parameter int ERASE_CYCLES = flash_self_access_pkg::ERASE_CYCLES,
  parameter int PROG_CYCLES = flash_self_access_pkg::PROG_CYCLES,
  parameter int EE_CYCLES = flash_self_access_pkg::EE_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Abort cause, level from the reset logic (pin or watchdog)
  input wire logic abort_reset,
  // Program memory array port
  output logic mem_rd,
  output logic [21:0] mem_rd_addr,
  input wire logic [7:0] mem_rd_data,
  output logic mem_prog,
  output logic mem_erase,
  output logic mem_cfg,
  output logic [21:0] mem_addr,
  output logic [63:0] mem_block,
  // EEPROM port
  output logic ee_rd,
  output logic ee_wr,
  output logic [7:0] ee_addr,
  output logic [7:0] ee_wdata,
  input wire logic [7:0] ee_rdata,
  output logic fetch_stall
);
  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] latch_q;
  logic [21:0] ptr_q;
  logic [7:0] hold_q [flash_self_access_pkg::HOLD_REGS];
  logic [7:0] ee_addr_q;
  logic [7:0] ee_data_q;
  logic done_flag_q;
  logic abort_s1_q;
  logic abort_s2_q;
  logic ack_q;
  logic [1:0] kind_q;
  flash_self_access_pkg::unlock_t unlock_q;
  logic timer_busy;
  logic timer_done;
  logic wr_strobe;
  logic rd_strobe;
  logic [13:0] off;
  logic start_ok;
  logic rd_ok;
  logic [7:0] wbyte;
  logic [2:0] tbl_mode;
  logic [21:0] ptr_pre;
  logic rd_pend_q;
  logic kill_q;

  function automatic logic hit(input logic [13:0] a, input logic [13:0] o);
    return a == o;
  endfunction

  assign off = adr_i[13:0];
  assign wbyte = dat_i[7:0];
  // Single-cycle strobes on the first request cycle only
  assign wr_strobe = cyc_i && stb_i && we_i && !ack_q && sel_i[0];
  assign rd_strobe = cyc_i && stb_i && !we_i && !ack_q;
  assign ack_o = ack_q;
  assign tbl_mode = wbyte[2:0];
  assign fetch_stall = timer_busy;

  // Start only when permitted and the unlock pair just completed
  assign start_ok = wr_strobe && hit(off,
      flash_self_access_pkg::ACCESS_CTRL_OFF)
      && wbyte[flash_self_access_pkg::WR_START_BIT]
      && wbyte[flash_self_access_pkg::PERMIT_BIT]
      && ctrl_q[flash_self_access_pkg::PERMIT_BIT]
      && unlock_q == flash_self_access_pkg::ST_ARM2
      && !timer_busy;
  assign rd_ok = wr_strobe && hit(off,
      flash_self_access_pkg::ACCESS_CTRL_OFF)
      && wbyte[flash_self_access_pkg::RD_START_BIT]
      && !wbyte[flash_self_access_pkg::PGM_SEL_BIT]
      && !timer_busy;

  // ----------------------------------------------------------------------
  // Acknowledge: one cycle after request, dropped next cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= cyc_i && stb_i && !ack_q;
    end
  end

  // ----------------------------------------------------------------------
  // Abort cause synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      abort_s1_q <= 1'b0;
      abort_s2_q <= 1'b0;
      kill_q <= 1'b0;
    end else begin
      abort_s1_q <= abort_reset;
      abort_s2_q <= abort_s1_q;
      // Registered so the timer reset never glitches off its own busy
      kill_q <= abort_s2_q && timer_busy;
    end
  end

  // ----------------------------------------------------------------------
  // Unlock sequence tracker, the port itself holds nothing
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      unlock_q <= flash_self_access_pkg::ST_IDLE;
    end else if (wr_strobe) begin
      if (hit(off, flash_self_access_pkg::UNLOCK_PORT_OFF)) begin
        if (wbyte == flash_self_access_pkg::UNLOCK_KEY_1) begin
          unlock_q <= flash_self_access_pkg::ST_ARM1;
        end else if (wbyte == flash_self_access_pkg::UNLOCK_KEY_2 &&
                     unlock_q == flash_self_access_pkg::ST_ARM1) begin
          unlock_q <= flash_self_access_pkg::ST_ARM2;
        end else begin
          unlock_q <= flash_self_access_pkg::ST_IDLE;
        end
      end else begin
        // Any other write breaks the sequence
        unlock_q <= flash_self_access_pkg::ST_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q <= flash_self_access_pkg::CTRL_RESET;
      kind_q <= 2'h0;
    end else begin
      if (abort_s2_q && timer_busy) begin
        // Select bits left alone so the failed target stays visible
        ctrl_q[flash_self_access_pkg::ABORT_BIT] <= 1'b1;
        ctrl_q[flash_self_access_pkg::WR_START_BIT] <= 1'b0;
      end else if (timer_done) begin
        ctrl_q[flash_self_access_pkg::WR_START_BIT] <= 1'b0;
        ctrl_q[flash_self_access_pkg::ABORT_BIT] <= 1'b0;
        if (kind_q == 2'h1) begin
          ctrl_q[flash_self_access_pkg::ERASE_EN_BIT] <= 1'b0;
        end
      end else if (wr_strobe && hit(off,
                   flash_self_access_pkg::ACCESS_CTRL_OFF)) begin
        if (!timer_busy) begin
          ctrl_q[7:6] <= wbyte[7:6];
          ctrl_q[flash_self_access_pkg::ERASE_EN_BIT] <=
              wbyte[flash_self_access_pkg::ERASE_EN_BIT];
          ctrl_q[flash_self_access_pkg::ABORT_BIT] <=
              wbyte[flash_self_access_pkg::ABORT_BIT];
          ctrl_q[flash_self_access_pkg::PERMIT_BIT] <=
              wbyte[flash_self_access_pkg::PERMIT_BIT];
        end
        if (start_ok) begin
          ctrl_q[flash_self_access_pkg::WR_START_BIT] <= 1'b1;
          // Config space wins over program select
          if (wbyte[flash_self_access_pkg::CFG_SEL_BIT]) begin
            kind_q <= 2'h0;
          end else if (!wbyte[flash_self_access_pkg::PGM_SEL_BIT]) begin
            kind_q <= 2'h2;
          end else if (wbyte[flash_self_access_pkg::ERASE_EN_BIT]) begin
            kind_q <= 2'h1;
          end else begin
            kind_q <= 2'h0;
          end
        end
      end
      // Read start lasts only one cycle
      ctrl_q[flash_self_access_pkg::RD_START_BIT] <= rd_ok;
      ctrl_q[5] <= 1'b0;
    end
  end

  program_timer #(
    .ERASE_CYCLES(ERASE_CYCLES),
    .PROG_CYCLES(PROG_CYCLES),
    .EE_CYCLES(EE_CYCLES)
  ) u_timer (
    .clock(clock),
    .rst(rst || kill_q),
    .start(ctrl_q[flash_self_access_pkg::WR_START_BIT] && !timer_busy
           && !timer_done),
    .kind(kind_q),
    .busy(timer_busy),
    .done(timer_done)
  );

  // ----------------------------------------------------------------------
  // Array commands on completion
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_prog <= 1'b0;
      mem_erase <= 1'b0;
      mem_cfg <= 1'b0;
      mem_addr <= 22'h0;
      ee_wr <= 1'b0;
      mem_block <= 64'h0;
    end else begin
      // Only row and block sized commands exist, no bulk erase path
      mem_erase <= timer_done && kind_q == 2'h1;
      mem_prog <= timer_done && kind_q == 2'h0;
      ee_wr <= timer_done && kind_q == 2'h2;
      mem_cfg <= ctrl_q[flash_self_access_pkg::CFG_SEL_BIT];
      if (timer_done) begin
        if (kind_q == 2'h1) begin
          mem_addr <= {ptr_q[21:6], 6'h00};
        end else begin
          mem_addr <= {ptr_q[21:3], 3'h0};
        end
        // Bytes stored unchecked, decode is not this block's concern
        for (int i = 0; i < flash_self_access_pkg::HOLD_REGS; i++) begin
          mem_block[i*8 +: 8] <= hold_q[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Table pointer, latch and holding registers
  // ----------------------------------------------------------------------
  assign ptr_pre = (tbl_mode[1:0] == flash_self_access_pkg::PTR_PRE_INC) ?
      {ptr_q[21], ptr_q[20:0] + 21'h1} : ptr_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ptr_q <= 22'h0;
    end else if (wr_strobe && hit(off, flash_self_access_pkg::PTR_OFF))
        begin
      ptr_q <= dat_i[21:0];
    end else if (wr_strobe && !timer_busy &&
                 hit(off, flash_self_access_pkg::TABLE_OP_OFF)) begin
      unique case (tbl_mode[1:0])
        flash_self_access_pkg::PTR_KEEP: ptr_q <= ptr_q;
        flash_self_access_pkg::PTR_POST_INC:
          ptr_q <= {ptr_q[21], ptr_q[20:0] + 21'h1};
        flash_self_access_pkg::PTR_POST_DEC:
          ptr_q <= {ptr_q[21], ptr_q[20:0] - 21'h1};
        flash_self_access_pkg::PTR_PRE_INC: ptr_q <= ptr_pre;
      endcase
    end
  end

  // Address from the old pointer, or the incremented one in pre-inc mode; array data lands a cycle later
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_rd <= 1'b0;
      rd_pend_q <= 1'b0;
      mem_rd_addr <= 22'h0;
    end else begin
      mem_rd <= wr_strobe && !timer_busy &&
          hit(off, flash_self_access_pkg::TABLE_OP_OFF) &&
          !wbyte[flash_self_access_pkg::OP_WRITE_BIT];
      rd_pend_q <= mem_rd;
      mem_rd_addr <= ptr_pre;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      latch_q <= 8'h00;
    end else if (rd_pend_q) begin
      latch_q <= mem_rd_data;
    end else if (wr_strobe &&
                 hit(off, flash_self_access_pkg::TABLE_LATCH_OFF)) begin
      latch_q <= wbyte;
    end
  end

  for (genvar g = 0; g < flash_self_access_pkg::HOLD_REGS; g++) begin
      : g_hold
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        hold_q[g] <= 8'hff;
      end else if (wr_strobe && !timer_busy &&
                   hit(off, flash_self_access_pkg::TABLE_OP_OFF) &&
                   wbyte[flash_self_access_pkg::OP_WRITE_BIT] &&
                   ptr_pre[2:0] == 3'(g)) begin
        hold_q[g] <= latch_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // EEPROM registers, done flag
  // ----------------------------------------------------------------------
  assign ee_addr = ee_addr_q;
  assign ee_wdata = ee_data_q;
  assign ee_rd = ctrl_q[flash_self_access_pkg::RD_START_BIT];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ee_addr_q <= 8'h00;
      ee_data_q <= 8'h00;
    end else begin
      if (wr_strobe && hit(off, flash_self_access_pkg::EE_ADDR_OFF)) begin
        ee_addr_q <= wbyte;
      end
      if (ee_rd) begin
        ee_data_q <= ee_rdata;
      end else if (wr_strobe &&
                   hit(off, flash_self_access_pkg::EE_DATA_OFF)) begin
        ee_data_q <= wbyte;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      done_flag_q <= 1'b0;
    end else if (timer_done) begin
      done_flag_q <= 1'b1;
    end else if (wr_strobe && hit(off, flash_self_access_pkg::STATUS_OFF)
                 && wbyte[flash_self_access_pkg::DONE_FLAG_BIT]) begin
      done_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dat_o <= 32'h0;
    end else if (rd_strobe) begin
      if (hit(off, flash_self_access_pkg::ACCESS_CTRL_OFF)) begin
        dat_o <= {24'h0, ctrl_q};
      end else if (hit(off, flash_self_access_pkg::TABLE_LATCH_OFF)) begin
        dat_o <= {24'h0, latch_q};
      end else if (hit(off, flash_self_access_pkg::PTR_OFF)) begin
        dat_o <= {10'h0, ptr_q};
      end else if (hit(off, flash_self_access_pkg::STATUS_OFF)) begin
        dat_o <= {30'h0, timer_busy, done_flag_q};
      end else if (hit(off, flash_self_access_pkg::EE_ADDR_OFF)) begin
        dat_o <= {24'h0, ee_addr_q};
      end else if (hit(off, flash_self_access_pkg::EE_DATA_OFF)) begin
        dat_o <= {24'h0, ee_data_q};
      end else begin
        // Unlock port and unmapped addresses read zero
        dat_o <= 32'h0;
      end
    end
  end
endmodule

// file: flash_self_access_chk.sv
// Port checker for the flash self-access block
`timescale 1ns/100ps
module flash_self_access_chk #(
  parameter int ERASE_CYCLES = 20,
  parameter int PROG_CYCLES = 20,
  parameter int EE_CYCLES = 20
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic abort_reset,
  input wire logic mem_rd,
  input wire logic [21:0] mem_rd_addr,
  input wire logic [7:0] mem_rd_data,
  input wire logic mem_prog,
  input wire logic mem_erase,
  input wire logic mem_cfg,
  input wire logic [21:0] mem_addr,
  input wire logic [63:0] mem_block,
  input wire logic ee_rd,
  input wire logic ee_wr,
  input wire logic [7:0] ee_addr,
  input wire logic [7:0] ee_wdata,
  input wire logic [7:0] ee_rdata,
  input wire logic fetch_stall
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  localparam int MAX_STALL = ERASE_CYCLES + PROG_CYCLES + EE_CYCLES + 8;
  int stall_cnt;
  logic abort_seen;
  logic cmd_q;
  wire cmd = mem_prog || mem_erase || ee_wr;
  wire ctrl_rd = ack_o && !we_i && adr_i[13:0] ==
    flash_self_access_pkg::ACCESS_CTRL_OFF;
  wire unl_rd = ack_o && !we_i && adr_i[13:0] ==
    flash_self_access_pkg::UNLOCK_PORT_OFF;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) stall_cnt <= 0;
    else if (fetch_stall) stall_cnt <= stall_cnt + 1;
    else stall_cnt <= 0;
  end
  // Held across the stall so the abort-ended fall is not judged
  always_ff @(posedge clock or posedge rst) begin
    if (rst) abort_seen <= 1'b0;
    else if (abort_reset) abort_seen <= 1'b1;
    else if (!fetch_stall) abort_seen <= 1'b0;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) cmd_q <= 1'b0;
    else cmd_q <= cmd;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_ack_once; ack_o ##1 !ack_o; endsequence
  sequence s_cmd_near; ##[0:2] (cmd || cmd_q); endsequence
  property p_ack; cyc_i && stb_i && !ack_o |=> s_ack_once; endproperty
  property p_unlock_zero; unl_rd |-> dat_o == 32'h0; endproperty
  property p_ctrl_layout;
    ctrl_rd |-> dat_o[31:8] == 24'h0 && !dat_o[5];
  endproperty
  property p_erase_align;
    mem_erase |-> mem_addr[5:0] == 6'h00 && !mem_prog && !ee_wr;
  endproperty
  property p_prog_align;
    mem_prog |-> mem_addr[2:0] == 3'h0 ##1 !mem_prog;
  endproperty
  property p_cmd_after_stall;
    cmd |-> $past(fetch_stall) || $past(fetch_stall, 2);
  endproperty
  property p_stall_end; $fell(fetch_stall) && !abort_seen |-> s_cmd_near;
  endproperty
  property p_stall_bound; fetch_stall |-> stall_cnt < MAX_STALL;
  endproperty
  property p_ee_rd; ee_rd |-> !mem_cfg ##1 !ee_rd; endproperty
  property p_abort_quiet; abort_seen && $past(abort_seen, 3) |-> !cmd;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle");
  a_unlock_zero: assert property (p_unlock_zero)
    else $error("unlock port read not zero");
  a_ctrl_layout: assert property (p_ctrl_layout)
    else $error("control unused bits set");
  a_erase_align: assert property (p_erase_align)
    else $error("erase row misaligned");
  a_prog_align: assert property (p_prog_align)
    else $error("program block misaligned");
  a_cmd_after_stall: assert property (p_cmd_after_stall)
    else $error("command without stall");
  a_stall_end: assert property (p_stall_end)
    else $error("stall ended without command");
  a_stall_bound: assert property (p_stall_bound)
    else $error("stall too long");
  a_ee_rd: assert property (p_ee_rd)
    else $error("eeprom read bad");
  a_abort_quiet: assert property (p_abort_quiet)
    else $error("command after abort");
endmodule

// file: flash_self_access_pkg.sv
// Constants shared by the flash self-access sequencer
package flash_self_access_pkg;
  // ----------------------------------------------------------------------
  // Register byte addresses (Wishbone, one word each)
  // ----------------------------------------------------------------------
  localparam logic [11:0] MEM_ACCESS_CONTROL_ADDR = 12'hfa6;
  localparam logic [13:0] MEM_ACCESS_CONTROL_BYTE = 14'h3e98;
  localparam logic [13:0] ACCESS_CTRL_OFF = 14'h3e98;
  localparam logic [13:0] UNLOCK_PORT_OFF = 14'h0000;
  localparam logic [13:0] TABLE_LATCH_OFF = 14'h0004;
  localparam logic [13:0] PTR_OFF = 14'h0008;
  localparam logic [13:0] TABLE_OP_OFF = 14'h000c;
  localparam logic [13:0] STATUS_OFF = 14'h0010;
  localparam logic [13:0] EE_ADDR_OFF = 14'h0014;
  localparam logic [13:0] EE_DATA_OFF = 14'h0018;
  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int PGM_SEL_BIT = 7;
  localparam int CFG_SEL_BIT = 6;
  localparam int ERASE_EN_BIT = 4;
  localparam int ABORT_BIT = 3;
  localparam int PERMIT_BIT = 2;
  localparam int WR_START_BIT = 1;
  localparam int RD_START_BIT = 0;
  localparam int DONE_FLAG_BIT = 0;
  localparam int STALL_BIT = 1;
  // Table operation command: bit 2 write, bits 1:0 pointer mode
  localparam int OP_WRITE_BIT = 2;
  localparam logic [1:0] PTR_KEEP = 2'h0;
  localparam logic [1:0] PTR_POST_INC = 2'h1;
  localparam logic [1:0] PTR_POST_DEC = 2'h2;
  localparam logic [1:0] PTR_PRE_INC = 2'h3;
  // ----------------------------------------------------------------------
  // Unlock keys and sizes
  // ----------------------------------------------------------------------
  localparam logic [7:0] UNLOCK_KEY_1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_2 = 8'haa;
  localparam int HOLD_REGS = 8;
  localparam int ROW_BYTES = 64;
  localparam int PTR_W = 22;
  localparam int PTR_STEP_W = 21;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLOCK_MHZ = 200;
  localparam int ERASE_TIME_US = 2000;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLOCK_MHZ;
  localparam int PROG_TIME_US = 2000;
  localparam int PROG_CYCLES = PROG_TIME_US * CLOCK_MHZ;
  localparam int EE_TIME_US = 4000;
  localparam int EE_CYCLES = EE_TIME_US * CLOCK_MHZ;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARM1 = 2'b01,
    ST_ARM2 = 2'b11
  } unlock_t;
endpackage

// file: flash_self_access_tb.sv
// Testbench for the flash self-access block
`timescale 1ns/100ps
module flash_self_access_tb;
  localparam logic [13:0] CTRL = flash_self_access_pkg::ACCESS_CTRL_OFF;
  localparam logic [13:0] UNL = flash_self_access_pkg::UNLOCK_PORT_OFF;
  localparam logic [13:0] LAT = flash_self_access_pkg::TABLE_LATCH_OFF;
  localparam logic [13:0] PTR = flash_self_access_pkg::PTR_OFF;
  localparam logic [13:0] OP = flash_self_access_pkg::TABLE_OP_OFF;
  localparam logic [13:0] STS = flash_self_access_pkg::STATUS_OFF;
  logic clock = 0, rst = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic abort_reset = 0;
  logic [15:0] adr_i = 16'h0000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic ack_o, mem_rd, mem_prog, mem_erase, mem_cfg;
  logic ee_rd, ee_wr, fetch_stall;
  logic [21:0] mem_rd_addr, mem_addr;
  logic [7:0] mem_rd_data, ee_addr, ee_wdata, ee_rdata;
  logic [63:0] mem_block;
  logic hit;
  logic [21:0] ha;
  logic [63:0] hb;
  logic [31:0] q;
  int fail_count = 0, num_checks = 0;
  always #2.5 clock = ~clock;
  flash_self_access #(.ERASE_CYCLES(20), .PROG_CYCLES(20), .EE_CYCLES(20))
  uut (.clock, .rst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .abort_reset, .mem_rd, .mem_rd_addr, .mem_rd_data,
    .mem_prog, .mem_erase, .mem_cfg, .mem_addr, .mem_block, .ee_rd,
    .ee_wr, .ee_addr, .ee_wdata, .ee_rdata, .fetch_stall);
  flash_array_model far (.clock, .rst, .mem_rd, .mem_rd_addr, .ee_rd,
    .ee_addr, .mem_rd_data, .ee_rdata);
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Waits on ack for up to 20 cycles, then fails and ends the run; no fixed slave latency is assumed
  task automatic bus(input logic w, input logic [13:0] a,
    input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clock);
    cyc_i <= 1; stb_i <= 1; we_i <= w;
    adr_i <= {2'b00, a}; dat_i <= d; sel_i <= 4'hf;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    r = dat_o;
    cyc_i <= 0; stb_i <= 0; we_i <= 0;
    if (n >= 20) begin
      fail_count++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rc(input logic [13:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(r, e);
  endtask
  task automatic start(input logic [7:0] c);
    wr(UNL, 32'h55);
    wr(UNL, 32'haa);
    wr(CTRL, {24'h0, c});
  endtask
  // Bounded watch for the array command after a start
  task automatic run_op;
    hit = 0;
    for (int n = 0; n < 60 && !hit; n++) begin
      @(posedge clock);
      if (mem_prog || mem_erase || ee_wr) begin
        hit = 1; ha = mem_addr; hb = mem_block;
      end
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rc(CTRL, 32'h0);
    wr(UNL, 32'h55);
    rc(UNL, 32'h0);
    rc(14'h0200, 32'h0);
    wr(LAT, 32'ha5);
    rc(LAT, 32'ha5);
  endtask
  task automatic t_table;
    logic [21:0] at [4] = '{22'h10, 22'h10, 22'h10, 22'h11};
    logic [21:0] pe [4] = '{22'h10, 22'h11, 22'h0f, 22'h11};
    for (int m = 0; m < 4; m++) begin
      wr(PTR, 32'h10);
      wr(OP, m);
      rc(LAT, {24'h0, at[m][7:0] ^ 8'h5a});
      rc(PTR, {10'h0, pe[m]});
    end
    wr(PTR, 32'h3fffff);
    wr(OP, 32'h1);
    rc(LAT, 32'ha5);
    rc(PTR, 32'h200000);
  endtask
  task automatic t_lock;
    wr(CTRL, 32'h84);
    wr(CTRL, 32'h86);
    run_op();
    check(hit, 0);
    wr(UNL, 32'h55);
    wr(UNL, 32'haa);
    wr(LAT, 32'h00);
    wr(CTRL, 32'h86);
    run_op();
    check(hit, 0);
    rc(CTRL, 32'h84);
    wr(CTRL, 32'h80);
    start(8'h82);
    run_op();
    check(hit, 0);
  endtask
  task automatic t_prog;
    wr(PTR, 32'hff);
    for (int i = 0; i < 8; i++) begin
      wr(LAT, 32'h10 + i);
      wr(OP, 32'h7);
    end
    wr(CTRL, 32'h84);
    start(8'h86);
    run_op();
    check(hit, 1);
    check(ha, 22'h100);
    check(hb, 64'h1716151413121110);
    rc(CTRL, 32'h84);
    rc(STS, 32'h1);
    wr(STS, 32'h1);
    rc(STS, 32'h0);
  endtask
  task automatic t_abort;
    wr(CTRL, 32'hc4);
    start(8'hc6);
    repeat (5) @(posedge clock);
    abort_reset <= 1;
    repeat (6) @(posedge clock);
    abort_reset <= 0;
    run_op();
    check(hit, 0);
    bus(1'b0, CTRL, 32'h0, q);
    check(q & 32'hca, 32'hc8);
    check(mem_cfg, 1'b1);
  endtask
  task automatic t_erase;
    wr(PTR, 32'h12345);
    wr(CTRL, 32'h94);
    start(8'h96);
    run_op();
    check(hit, 1);
    check(ha, 22'h12340);
    rc(CTRL, 32'h84);
  endtask
  task automatic t_ee;
    wr(CTRL, 32'h00);
    wr(flash_self_access_pkg::EE_ADDR_OFF, 32'h5a);
    wr(CTRL, 32'h01);
    rc(flash_self_access_pkg::EE_DATA_OFF, 32'h99);
    rc(CTRL, 32'h00);
    wr(CTRL, 32'h80);
    wr(CTRL, 32'h81);
    rc(CTRL, 32'h80);
    wr(CTRL, 32'h04);
    start(8'h06);
    run_op();
    check({hit, ee_addr, ee_wdata}, 17'h15a99);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst <= 0;
    t_reset();
    t_table();
    t_lock();
    t_prog();
    t_abort();
    t_erase();
    t_ee();
    finish_test();
  end
endmodule
bind flash_self_access flash_self_access_chk #(
  .ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES),
  .EE_CYCLES(EE_CYCLES)
) u_chk (.clock, .rst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
  .dat_o, .ack_o, .abort_reset, .mem_rd, .mem_rd_addr, .mem_rd_data,
  .mem_prog, .mem_erase, .mem_cfg, .mem_addr, .mem_block, .ee_rd,
  .ee_wr, .ee_addr, .ee_wdata, .ee_rdata, .fetch_stall);

// file: program_timer.sv
// Self-timed programming interval counter
`timescale 1ns/100ps
module program_timer #(
  parameter int ERASE_CYCLES = 400000,
  parameter int PROG_CYCLES = 400000,
  parameter int EE_CYCLES = 800000
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic [1:0] kind,
  output logic busy,
  output logic done
);
  logic [31:0] count_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_q <= 32'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        unique case (kind)
          2'h1: count_q <= 32'(ERASE_CYCLES - 1);
          2'h2: count_q <= 32'(EE_CYCLES - 1);
          default: count_q <= 32'(PROG_CYCLES - 1);
        endcase
      end else if (busy) begin
        if (count_q == 32'h0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count_q <= count_q - 32'h1;
        end
      end
    end
  end
endmodule
